// file: rtl/ldrq_pkg.sv
// package for the load-store data bus request phase
package ldrq_pkg;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int          ADDR_W      = 32;
  localparam int          DATA_W      = 32;
  localparam int          PROT_W      = 3;
  localparam int          MEMTYPE_W   = 2;
  localparam logic        REQ_RST     = 1'h0;
  localparam logic [31:0] WORD_RST    = 32'h00000000;
  localparam logic [2:0]  PROT_RST    = 3'h0;
  localparam logic [1:0]  MEMTYPE_RST = 2'h0;

  // ------------------------------------------------------------
  // address phase carrier
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    wdata;
    logic                 we;
    logic [PROT_W-1:0]    prot;
    logic [MEMTYPE_W-1:0] memtype;
  } ldrq_attr_type;

  typedef enum logic [0:0] {
    LDRQ_IDLE = 1'b0,
    LDRQ_PEND = 1'b1
  } ldrq_state_type;

endpackage

// file: rtl/ldrq_request_phase.sv
// request phase of the load-store unit data bus
//
// Summary of operation
// - once request valid is raised it stays high until grant is seen high for one cycle.
// - the request parity output is always the inverse of request valid.
// - protection, write data and write enable stay stable while pending and change only after grant.
// - the address is presented in the same cycle that request valid is raised.
// - the memory attributes are presented together with request valid.
// - write enable is high for writes and low for reads alongside request valid.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// holding register for one address phase field
// ------------------------------------------------------------
module ldrq_hold_reg #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  // a zero width field cannot be held
  if (WIDTH < 1) begin : gen_bad_width
    $error("hold register width must be at least one");
  end

  // load only on the cycle the core hands over a request
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_o <= RST_VALUE;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end

endmodule

// ------------------------------------------------------------
// request phase
// ------------------------------------------------------------
module ldrq_request_phase #(
  parameter int ADDR_WIDTH    = ldrq_pkg::ADDR_W,
  parameter int DATA_WIDTH    = ldrq_pkg::DATA_W,
  parameter int PROT_WIDTH    = ldrq_pkg::PROT_W,
  parameter int MEMTYPE_WIDTH = ldrq_pkg::MEMTYPE_W
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    resetn_i,
  // core side
  input  wire logic                    core_req_i,
  input  wire ldrq_pkg::ldrq_attr_type core_attr_i,
  output logic                         core_busy_o,
  output logic                         core_accept_o,
  // bus side
  output logic                         data_req_o,
  output logic                         data_reqpar_o,
  input  wire logic                    data_gnt_i,
  input  wire logic                    data_gntpar_i,
  output ldrq_pkg::ldrq_attr_type      data_attr_o,
  output logic                         gnt_par_err_o
);
  import ldrq_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the carrier struct fixes every field width, so only its widths fit
  if (ADDR_WIDTH != ADDR_W) begin : gen_bad_addr
    $error("address width must match the carrier");
  end
  if (DATA_WIDTH != DATA_W) begin : gen_bad_data
    $error("write data width must match the carrier");
  end
  if (PROT_WIDTH != PROT_W) begin : gen_bad_prot
    $error("protection width must match the carrier");
  end
  if (MEMTYPE_WIDTH != MEMTYPE_W) begin : gen_bad_memtype
    $error("memory type width must match the carrier");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  ldrq_state_type           state;
  ldrq_state_type           next_state;
  logic                     accept;
  logic                     attr_load;
  logic [ADDR_WIDTH-1:0]    held_addr;
  logic [DATA_WIDTH-1:0]    held_wdata;
  logic                     held_we;
  logic [PROT_WIDTH-1:0]    held_prot;
  logic [MEMTYPE_WIDTH-1:0] held_memtype;

  // ------------------------------------------------------------
  // handshake
  // ------------------------------------------------------------
  // pending request valid
  assign data_req_o    = (state == LDRQ_PEND);
  assign accept        = data_req_o & data_gnt_i;
  assign core_accept_o = accept;
  // core may load a new request when idle or on the granting cycle
  assign core_busy_o   = data_req_o & ~data_gnt_i;
  assign attr_load     = core_req_i & ~core_busy_o;

  always_comb begin
    next_state = state;
    case (state)
      LDRQ_IDLE: begin
        if (core_req_i) begin
          next_state = LDRQ_PEND;
        end
      end
      LDRQ_PEND: begin
        if (accept && !core_req_i) begin
          next_state = LDRQ_IDLE;
        end
      end
      default: begin
        next_state = LDRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= LDRQ_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      data_reqpar_o <= ~REQ_RST;
    end else begin
      data_reqpar_o <= (next_state != LDRQ_PEND);
    end
  end

  // ------------------------------------------------------------
  // address phase attributes
  // ------------------------------------------------------------
  // frozen while pending
  ldrq_hold_reg #(
    .WIDTH     (ADDR_WIDTH),
    .RST_VALUE (WORD_RST)
  ) addr_hold (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (attr_load),
    .d_i       (core_attr_i.addr),
    .q_o       (held_addr)
  );

  ldrq_hold_reg #(
    .WIDTH     (DATA_WIDTH),
    .RST_VALUE (WORD_RST)
  ) wdata_hold (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (attr_load),
    .d_i       (core_attr_i.wdata),
    .q_o       (held_wdata)
  );

  ldrq_hold_reg #(
    .WIDTH     (1),
    .RST_VALUE (REQ_RST)
  ) we_hold (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (attr_load),
    .d_i       (core_attr_i.we),
    .q_o       (held_we)
  );

  ldrq_hold_reg #(
    .WIDTH     (PROT_WIDTH),
    .RST_VALUE (PROT_RST)
  ) prot_hold (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (attr_load),
    .d_i       (core_attr_i.prot),
    .q_o       (held_prot)
  );

  ldrq_hold_reg #(
    .WIDTH     (MEMTYPE_WIDTH),
    .RST_VALUE (MEMTYPE_RST)
  ) memtype_hold (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (attr_load),
    .d_i       (core_attr_i.memtype),
    .q_o       (held_memtype)
  );

  // one driver for the whole carrier
  assign data_attr_o = '{
    addr:    held_addr,
    wdata:   held_wdata,
    we:      held_we,
    prot:    held_prot,
    memtype: held_memtype
  };

  // ------------------------------------------------------------
  // grant integrity
  // ------------------------------------------------------------
  // grant parity check
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gnt_par_err_o <= 1'b0;
    end else begin
      gnt_par_err_o <= ~(data_gnt_i ^ data_gntpar_i);
    end
  end

endmodule

`default_nettype wire

// file: bench/ldrq_bus_model.sv
// grant side model of the data bus
`timescale 1ns/10ps
`default_nettype none
module ldrq_bus_model (
  input  wire logic ref_clk_i,
  input  wire logic resetn_i,
  input  wire logic go_i,
  input  wire logic bad_i,
  input  wire logic req_i,
  output logic      gnt_o,
  output logic      gntpar_o,
  output logic      rvalid_o
);
  assign gntpar_o = gnt_o ^ ~bad_i;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gnt_o <= 1'h0;
    end else begin
      gnt_o <= go_i;
    end
  end
  // one response pulse per granted request
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rvalid_o <= 1'h0;
    end else begin
      rvalid_o <= gnt_o && req_i;
    end
  end
endmodule
`default_nettype wire

// file: bench/ldrq_request_phase_sva.sv
// assertions on the request phase ports
`timescale 1ns/10ps
`default_nettype none
module ldrq_request_phase_sva (
  input wire logic ref_clk_i, resetn_i, core_req_i, core_busy_o, core_accept_o,
  input wire logic data_req_o, data_reqpar_o, data_gnt_i, data_gntpar_i, gnt_par_err_o,
  input wire ldrq_pkg::ldrq_attr_type core_attr_i, data_attr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence take_s; core_req_i && !core_busy_o; endsequence
  sequence wait_s; data_req_o && !data_gnt_i; endsequence
  req_hold_a: assert property (wait_s |=> data_req_o) else $error("req dropped");
  req_par_a: assert property (data_reqpar_o != data_req_o) else $error("req parity");
  gnt_chk_a: assert property (data_gnt_i == data_gntpar_i |=> gnt_par_err_o) else $error("gnt parity");
  attr_hold_a: assert property (wait_s |=> $stable(data_attr_o)) else $error("attr moved");
  attr_load_a: assert property (take_s |=> data_req_o && data_attr_o == $past(core_attr_i))
    else $error("attr not sent");
  accept_pulse_a: assert property (core_accept_o && !core_req_i |=> !data_req_o && data_reqpar_o)
    else $error("accept");
  gnt_ok_a: assert property (data_gnt_i != data_gntpar_i |=> !gnt_par_err_o) else $error("gnt parity ok");
  lone_gnt_a: assert property (!core_req_i && !core_busy_o |=> !data_req_o) else $error("stray req");
endmodule
bind ldrq_request_phase ldrq_request_phase_sva chk (.ref_clk_i, .resetn_i, .core_req_i, .core_busy_o,
  .core_accept_o, .data_req_o, .data_reqpar_o, .data_gnt_i, .data_gntpar_i, .gnt_par_err_o, .core_attr_i,
  .data_attr_o);
`default_nettype wire

// file: bench/test_ldrq_request_phase.sv
// random bench for the request phase
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module test_ldrq_request_phase;
  import ldrq_pkg::*;
  logic ref_clk_i = 0, resetn_i = 0, core_req_i = 0, go = 0, bad = 0, e_req = 0, e_err = 0;
  logic core_busy_o, core_accept_o, data_req_o, data_reqpar_o, gnt, gntpar, gnt_par_err_o, rvalid;
  ldrq_attr_type core_attr_i = '0, data_attr_o, e_attr = '0;
  int seed = 43, bad_count = 0, tests_run = 0, n_acc = 0, n_rsp = 0;
  initial forever #2 ref_clk_i = ~ref_clk_i;
  ldrq_request_phase uut (.ref_clk_i, .resetn_i, .core_req_i, .core_attr_i, .core_busy_o, .core_accept_o,
    .data_req_o, .data_reqpar_o, .data_gnt_i(gnt), .data_gntpar_i(gntpar), .data_attr_o, .gnt_par_err_o);
  ldrq_bus_model bus (.ref_clk_i, .resetn_i, .go_i(go), .bad_i(bad), .req_i(data_req_o), .gnt_o(gnt),
    .gntpar_o(gntpar), .rvalid_o(rvalid));
  // expected request and attributes from inputs alone
  always @(posedge ref_clk_i) if (resetn_i) begin
    e_err <= gnt == gntpar;
    if (!(e_req && !gnt)) begin
      e_req <= core_req_i;
      if (core_req_i) e_attr <= core_attr_i;
    end
  end
  always @(negedge ref_clk_i) if (resetn_i) begin
    `CHK(data_req_o, e_req)
    `CHK(data_reqpar_o, !e_req)
    `CHK(data_attr_o, e_attr)
    `CHK(gnt_par_err_o, e_err)
    `CHK(core_accept_o, e_req && gnt)
    `CHK(core_busy_o, e_req && !gnt)
    n_acc += core_accept_o;
    n_rsp += rvalid;
  end
  task automatic conclude();
    $display("compared %0d, mismatched %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // test 0 back to back, 1 random stalls, 2 lone grants with bad parity
  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1;
    for (int t = 0; t < 3; t++) begin
      repeat (300) begin
        @(posedge ref_clk_i);
        core_req_i <= t == 0 || (t == 1 && $random(seed) % 2);
        go <= t != 1 || $random(seed) % 3 == 0;
        bad <= t == 2 && $random(seed) % 2;
        core_attr_i <= 70'({$random(seed), $random(seed), $random(seed)});
      end
      $display("test %0d done, mismatches %0d", t, bad_count);
    end
    repeat (2) @(posedge ref_clk_i);
    `CHK(n_rsp, n_acc)
    conclude();
  end
endmodule
`default_nettype wire
